/* File: rtl/sbb_pkg.sv */
package sbb_pkg;

    // widths of the emulated bus, default list size and step counter width
    localparam int ADDR_W     = 24;
    localparam int OPC_W      = 16;
    localparam int NUM_BP_DEF = 16;
    localparam int STEP_W_DEF = 16;

    // undefined instruction used as the breakpoint marker
    localparam logic [OPC_W-1:0] MARKER_CODE = 16'h5770;

    typedef logic [ADDR_W-1:0] sbb_addr_t;
    typedef logic [OPC_W-1:0]  sbb_opc_t;

    // one breakpoint list entry
    typedef struct packed {
        logic      used;
        logic      pending;
        sbb_addr_t addr;
        sbb_opc_t  opcode;
    } sbb_entry_t;

    // host commands
    typedef enum logic [2:0] {
        CMD_RUN        = 3'h0,
        CMD_BREAK      = 3'h1,
        CMD_STEP       = 3'h2,
        CMD_BP_SET     = 3'h3,
        CMD_BP_CLR     = 3'h4,
        CMD_BP_CLR_ALL = 3'h5,
        CMD_BP_EN      = 3'h6,
        CMD_BP_DIS     = 3'h7
    } sbb_cmd_t;

    // controller states
    typedef enum logic [2:0] {
        ST_MON  = 3'h0,
        ST_RUN  = 3'h1,
        ST_HOLD = 3'h2,
        ST_MRD  = 3'h3,
        ST_MWR  = 3'h4,
        ST_WALK = 3'h5
    } sbb_state_t;

    // table jobs carried out through the memory port
    typedef enum logic [2:0] {
        JOB_PLANT   = 3'h0,
        JOB_CLEAR   = 3'h1,
        JOB_HIT     = 3'h2,
        JOB_EN      = 3'h3,
        JOB_DIS     = 3'h4,
        JOB_CLR_ALL = 3'h5
    } sbb_job_t;

endpackage

/* File: rtl/sbb_tbl_if.sv */
`timescale 1ns/1ps
interface sbb_tbl_if #(parameter int IDX_W = 4);
    logic               wr_en;
    logic [IDX_W-1:0]   wr_idx;
    sbb_pkg::sbb_entry_t wr_ent;
    logic [IDX_W-1:0]   rd_idx;
    sbb_pkg::sbb_entry_t rd_ent;
    sbb_pkg::sbb_addr_t look_addr;
    logic               hit;
    logic [IDX_W-1:0]   hit_idx;
    logic               free_ok;
    logic [IDX_W-1:0]   free_idx;

    modport ctl (output wr_en, wr_idx, wr_ent, rd_idx, look_addr,
                 input  rd_ent, hit, hit_idx, free_ok, free_idx);
    modport tbl (input  wr_en, wr_idx, wr_ent, rd_idx, look_addr,
                 output rd_ent, hit, hit_idx, free_ok, free_idx);
endinterface

/* File: rtl/sbb_bp_table.sv */
`timescale 1ns/1ps
module sbb_bp_table #(
    parameter int NUM_BP = 16,
    parameter int IDX_W  = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // table port
    sbb_tbl_if.tbl   tif
);

    typedef struct packed {
        sbb_pkg::sbb_entry_t [NUM_BP-1:0] ent;
    } sbb_tbl_state_t;

    sbb_tbl_state_t r_reg;
    sbb_tbl_state_t r_next;

    // single write port, one entry per cycle
    always_comb
    begin
        r_next = r_reg;
        if (tif.wr_en)
        begin
            r_next.ent[tif.wr_idx] = tif.wr_ent;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // address match and first free slot; lowest index wins
    always_comb
    begin
        tif.hit      = 1'b0;
        tif.hit_idx  = '0;
        tif.free_ok  = 1'b0;
        tif.free_idx = '0;
        for (int i = NUM_BP - 1; i >= 0; i--)
        begin
            if (r_reg.ent[i].used && r_reg.ent[i].addr == tif.look_addr)
            begin
                tif.hit     = 1'b1;
                tif.hit_idx = IDX_W'(i);
            end
            if (!r_reg.ent[i].used)
            begin
                tif.free_ok  = 1'b1;
                tif.free_idx = IDX_W'(i);
            end
        end
        tif.rd_ent = r_reg.ent[tif.rd_idx];
    end

endmodule

/* File: rtl/sbb_break_ctrl.sv */
// Behaviour
// - break command stops the user program and enters monitor; run resumes it
// - break during burst dma waits until the transfer completes
// - breakpoint marker is the undefined opcode 5770 hex
// - defining (while enabled) or enabling a breakpoint saves the opcode and writes the marker
// - enabled marker fetch raises a break exactly like a break command
// - marker fetch address is matched against the breakpoint list
// - planted hit enters monitor, restores opcode, next run starts there
// - unlisted marker still enters monitor and flags undefined breakpoint
// - disabling breakpoints writes every saved opcode back
// - list size is a parameter, not a fixed architectural limit
// - breakpoints start disabled after reset
// - clear removes entry, restores opcode if pending; clear-all removes all
// - step runs one or n instructions from pc or given address
// - planted hit shows both hit status and monitor status
`timescale 1ns/1ps
module sbb_break_ctrl #(
    parameter int NUM_BP = sbb_pkg::NUM_BP_DEF,
    parameter int STEP_W = sbb_pkg::STEP_W_DEF
) (
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    // host commands
    input  wire logic               cmd_valid,
    input  wire sbb_pkg::sbb_cmd_t  cmd_op,
    input  wire sbb_pkg::sbb_addr_t cmd_addr,
    input  wire logic               cmd_use_addr,
    input  wire logic [STEP_W-1:0]  cmd_count,
    output logic                    cmd_ready,
    // processor core
    input  wire logic               fetch_valid,
    input  wire sbb_pkg::sbb_addr_t fetch_addr,
    input  wire sbb_pkg::sbb_opc_t  fetch_data,
    input  wire logic               insn_done,
    input  wire logic               dma_burst_busy,
    output logic                    core_run,
    output logic                    pc_load,
    output sbb_pkg::sbb_addr_t      pc_load_addr,
    // target memory
    output logic                    mem_req,
    output logic                    mem_we,
    output sbb_pkg::sbb_addr_t      mem_addr,
    output sbb_pkg::sbb_opc_t       mem_wdata,
    input  wire logic               mem_ack,
    input  wire sbb_pkg::sbb_opc_t  mem_rdata,
    // status
    output logic                    in_monitor,
    output logic                    bp_hit,
    output logic                    undef_bp,
    output logic                    step_done,
    output logic                    sw_bp_enabled,
    output logic                    tbl_full
);

    localparam int               IDX_W    = $clog2(NUM_BP);
    localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(NUM_BP - 1);
    localparam logic [IDX_W-1:0] IDX_ONE  = IDX_W'(1);
    localparam logic [STEP_W-1:0] STEP_ONE = STEP_W'(1);

    typedef struct packed {
        sbb_pkg::sbb_state_t st;
        sbb_pkg::sbb_job_t   job;
        logic                enabled;
        logic [IDX_W-1:0]    idx;
        logic                hit;
        logic                marker;
        sbb_pkg::sbb_opc_t   opc;
        logic                step_active;
        logic [STEP_W-1:0]   step_cnt;
        sbb_pkg::sbb_addr_t  mem_addr;
        sbb_pkg::sbb_opc_t   mem_wdata;
        logic                mem_req;
        logic                mem_we;
        logic                core_run;
        logic                pc_load;
        sbb_pkg::sbb_addr_t  pc_addr;
        logic                in_monitor;
        logic                bp_hit;
        logic                undef_bp;
        logic                step_done;
        logic                tbl_full;
        logic                cmd_ready;
    } sbb_ctl_state_t;

    sbb_ctl_state_t r_reg;
    sbb_ctl_state_t r_next;
    logic           take;
    logic           walk_more;
    logic           marker_seen;

    sbb_tbl_if #(.IDX_W(IDX_W)) tif ();

    sbb_bp_table #(
        .NUM_BP (NUM_BP),
        .IDX_W  (IDX_W)
    ) u_table (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tif     (tif.tbl)
    );

    // controller next state; table and memory jobs only run while in the monitor,
    // so the marker writes never race the core's own fetches
    always_comb
    begin
        r_next         = r_reg;
        r_next.pc_load = 1'b0;
        take           = cmd_valid && r_reg.cmd_ready;
        walk_more      = (r_reg.job == sbb_pkg::JOB_EN || r_reg.job == sbb_pkg::JOB_DIS
                         || r_reg.job == sbb_pkg::JOB_CLR_ALL) && r_reg.idx != IDX_LAST;
        marker_seen    = r_reg.enabled && fetch_valid
                         && fetch_data == sbb_pkg::MARKER_CODE;
        tif.wr_en      = 1'b0;
        tif.wr_idx     = r_reg.idx;
        tif.wr_ent     = tif.rd_ent;
        tif.rd_idx     = r_reg.idx;
        tif.look_addr  = (r_reg.st == sbb_pkg::ST_RUN) ? fetch_addr : cmd_addr;
        case (r_reg.st)
            sbb_pkg::ST_MON:
            begin
                if (take)
                begin
                    case (cmd_op)
                        sbb_pkg::CMD_RUN, sbb_pkg::CMD_STEP:
                        begin
                            r_next.core_run    = 1'b1;
                            r_next.bp_hit      = 1'b0;
                            r_next.undef_bp    = 1'b0;
                            r_next.step_done   = 1'b0;
                            r_next.hit         = 1'b0;
                            r_next.marker      = 1'b0;
                            r_next.pc_load     = cmd_use_addr;
                            r_next.pc_addr     = cmd_addr;
                            r_next.step_active = (cmd_op == sbb_pkg::CMD_STEP);
                            r_next.step_cnt    = (cmd_count == '0) ? STEP_ONE : cmd_count;
                            r_next.st          = sbb_pkg::ST_RUN;
                        end
                        sbb_pkg::CMD_BP_SET:
                        begin
                            if (!tif.hit && !tif.free_ok)
                            begin
                                r_next.tbl_full = 1'b1;
                            end
                            else if (!tif.hit)
                            begin
                                tif.wr_en  = 1'b1;
                                tif.wr_idx = tif.free_idx;
                                tif.wr_ent = '{used: 1'b1, pending: 1'b0,
                                               addr: cmd_addr, opcode: '0};
                                r_next.idx      = tif.free_idx;
                                r_next.mem_addr = cmd_addr;
                                r_next.job      = sbb_pkg::JOB_PLANT;
                                if (r_reg.enabled)
                                begin
                                    r_next.st = sbb_pkg::ST_MRD;
                                end
                            end
                        end
                        sbb_pkg::CMD_BP_CLR:
                        begin
                            if (tif.hit)
                            begin
                                r_next.idx      = tif.hit_idx;
                                r_next.job      = sbb_pkg::JOB_CLEAR;
                                r_next.tbl_full = 1'b0;
                                r_next.st       = sbb_pkg::ST_WALK;
                            end
                        end
                        sbb_pkg::CMD_BP_CLR_ALL:
                        begin
                            r_next.idx      = '0;
                            r_next.job      = sbb_pkg::JOB_CLR_ALL;
                            r_next.tbl_full = 1'b0;
                            r_next.st       = sbb_pkg::ST_WALK;
                        end
                        sbb_pkg::CMD_BP_EN:
                        begin
                            r_next.enabled = 1'b1;
                            r_next.idx     = '0;
                            r_next.job     = sbb_pkg::JOB_EN;
                            r_next.st      = sbb_pkg::ST_WALK;
                        end
                        sbb_pkg::CMD_BP_DIS:
                        begin
                            r_next.enabled = 1'b0;
                            r_next.idx     = '0;
                            r_next.job     = sbb_pkg::JOB_DIS;
                            r_next.st      = sbb_pkg::ST_WALK;
                        end
                        default:
                        begin
                            r_next.st = sbb_pkg::ST_MON; // break while halted does nothing
                        end
                    endcase
                end
            end
            sbb_pkg::ST_RUN:
            begin
                // a marker fetch outranks an explicit break in the same cycle
                if (marker_seen)
                begin
                    r_next.marker = 1'b1;
                    r_next.hit    = tif.hit;
                    r_next.idx    = tif.hit_idx;
                    r_next.st     = sbb_pkg::ST_HOLD;
                end
                else if (take && cmd_op == sbb_pkg::CMD_BREAK)
                begin
                    r_next.st = sbb_pkg::ST_HOLD;
                end
                else if (r_reg.step_active && insn_done)
                begin
                    if (r_reg.step_cnt == STEP_ONE)
                    begin
                        r_next.step_done = 1'b1;
                        r_next.st        = sbb_pkg::ST_HOLD;
                    end
                    else
                    begin
                        r_next.step_cnt = r_reg.step_cnt - STEP_ONE;
                    end
                end
            end
            sbb_pkg::ST_HOLD:
            begin
                if (!dma_burst_busy)
                begin
                    r_next.core_run    = 1'b0;
                    r_next.step_active = 1'b0;
                    if (r_reg.hit && tif.rd_ent.pending)
                    begin
                        r_next.job       = sbb_pkg::JOB_HIT;
                        r_next.mem_addr  = tif.rd_ent.addr;
                        r_next.mem_wdata = tif.rd_ent.opcode;
                        r_next.pc_load   = 1'b1;
                        r_next.pc_addr   = tif.rd_ent.addr;
                        r_next.st        = sbb_pkg::ST_MWR;
                    end
                    else
                    begin
                        r_next.undef_bp = r_reg.marker;
                        r_next.st       = sbb_pkg::ST_MON;
                    end
                end
            end
            sbb_pkg::ST_MRD:
            begin
                if (mem_ack)
                begin
                    r_next.opc       = mem_rdata;
                    r_next.mem_wdata = sbb_pkg::MARKER_CODE;
                    r_next.st        = sbb_pkg::ST_MWR;
                end
            end
            sbb_pkg::ST_MWR:
            begin
                if (mem_ack)
                begin
                    tif.wr_en = 1'b1;
                    if (r_reg.job == sbb_pkg::JOB_PLANT || r_reg.job == sbb_pkg::JOB_EN)
                    begin
                        tif.wr_ent.pending = 1'b1;
                        tif.wr_ent.opcode  = r_reg.opc;
                    end
                    else if (r_reg.job == sbb_pkg::JOB_HIT || r_reg.job == sbb_pkg::JOB_DIS)
                    begin
                        tif.wr_ent.pending = 1'b0;
                    end
                    else
                    begin
                        tif.wr_ent = '0;
                    end
                    if (r_reg.job == sbb_pkg::JOB_HIT)
                    begin
                        r_next.bp_hit = 1'b1;
                        r_next.st     = sbb_pkg::ST_MON;
                    end
                    else if (walk_more)
                    begin
                        r_next.idx = r_reg.idx + IDX_ONE;
                        r_next.st  = sbb_pkg::ST_WALK;
                    end
                    else
                    begin
                        r_next.st = sbb_pkg::ST_MON;
                    end
                end
            end
            sbb_pkg::ST_WALK:
            begin
                if (tif.rd_ent.pending && r_reg.job != sbb_pkg::JOB_EN)
                begin
                    r_next.mem_addr  = tif.rd_ent.addr;
                    r_next.mem_wdata = tif.rd_ent.opcode;
                    r_next.st        = sbb_pkg::ST_MWR;
                end
                else if (tif.rd_ent.used && !tif.rd_ent.pending
                         && r_reg.job == sbb_pkg::JOB_EN)
                begin
                    r_next.mem_addr = tif.rd_ent.addr;
                    r_next.st       = sbb_pkg::ST_MRD;
                end
                else
                begin
                    if (r_reg.job == sbb_pkg::JOB_CLEAR || r_reg.job == sbb_pkg::JOB_CLR_ALL)
                    begin
                        tif.wr_en  = 1'b1;
                        tif.wr_ent = '0;
                    end
                    if (walk_more)
                    begin
                        r_next.idx = r_reg.idx + IDX_ONE;
                    end
                    else
                    begin
                        r_next.st = sbb_pkg::ST_MON;
                    end
                end
            end
            default:
            begin
                r_next.st = sbb_pkg::ST_MON;
            end
        endcase
        // port-facing flags follow the next state so they leave a flop
        r_next.mem_req    = r_next.st == sbb_pkg::ST_MRD || r_next.st == sbb_pkg::ST_MWR;
        r_next.mem_we     = r_next.st == sbb_pkg::ST_MWR;
        r_next.in_monitor = r_next.st == sbb_pkg::ST_MON;
        r_next.cmd_ready  = r_next.st == sbb_pkg::ST_MON || r_next.st == sbb_pkg::ST_RUN;
    end

    // breakpoints come up disabled and the core halted in the monitor
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            r_reg            <= '0;
            r_reg.in_monitor <= 1'b1;
            r_reg.cmd_ready  <= 1'b1;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign cmd_ready     = r_reg.cmd_ready;
    assign core_run      = r_reg.core_run;
    assign pc_load       = r_reg.pc_load;
    assign pc_load_addr  = r_reg.pc_addr;
    assign mem_req       = r_reg.mem_req;
    assign mem_we        = r_reg.mem_we;
    assign mem_addr      = r_reg.mem_addr;
    assign mem_wdata     = r_reg.mem_wdata;
    assign in_monitor    = r_reg.in_monitor;
    assign bp_hit        = r_reg.bp_hit;
    assign undef_bp      = r_reg.undef_bp;
    assign step_done     = r_reg.step_done;
    assign sw_bp_enabled = r_reg.enabled;
    assign tbl_full      = r_reg.tbl_full;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    marker_plant_a:
        assert property (r_reg.st == sbb_pkg::ST_MRD && mem_ack
                         |=> mem_req && mem_we && mem_wdata == sbb_pkg::MARKER_CODE)
        else $error("marker not written after opcode read");
    run_resume_a:
        assert property (take && r_reg.st == sbb_pkg::ST_MON && cmd_op == sbb_pkg::CMD_RUN
                         |=> core_run && !in_monitor)
        else $error("run did not resume user program");
    break_stop_a:
        assert property (take && r_reg.st == sbb_pkg::ST_RUN && cmd_op == sbb_pkg::CMD_BREAK
                         && !marker_seen ##1 !dma_burst_busy |=> !core_run)
        else $error("break did not stop user program");
    dma_hold_a:
        assert property (r_reg.st == sbb_pkg::ST_HOLD && dma_burst_busy
                         |=> core_run && !in_monitor)
        else $error("monitor entered during burst dma");
    marker_trap_a:
        assert property (r_reg.st == sbb_pkg::ST_RUN && marker_seen
                         |=> r_reg.st == sbb_pkg::ST_HOLD && r_reg.marker)
        else $error("marker fetch did not raise a break");
    hit_restore_a:
        assert property (r_reg.st == sbb_pkg::ST_HOLD && !dma_burst_busy && r_reg.hit
                         && tif.rd_ent.pending
                         |=> mem_req && mem_we && pc_load && pc_load_addr == mem_addr)
        else $error("planted hit did not restore opcode");
    undef_flag_a:
        assert property (r_reg.st == sbb_pkg::ST_HOLD && !dma_burst_busy && r_reg.marker
                         && !(r_reg.hit && tif.rd_ent.pending) |=> undef_bp && in_monitor)
        else $error("stray marker not reported");
    hit_status_a:
        assert property ($rose(bp_hit) |-> in_monitor && !core_run)
        else $error("hit status without monitor");
    enable_cause_a:
        assert property ($rose(sw_bp_enabled)
                         |-> $past(take) && $past(cmd_op) == sbb_pkg::CMD_BP_EN)
        else $error("breakpoints enabled without command");
    step_end_a:
        assert property (r_reg.st == sbb_pkg::ST_RUN && r_reg.step_active && insn_done
                         && r_reg.step_cnt == STEP_ONE && !marker_seen && !take
                         |=> step_done ##1 ($past(dma_burst_busy) || !core_run))
        else $error("step count did not return to monitor");

    hit_taken_c:   cover property ($rose(bp_hit));
    undef_seen_c:  cover property ($rose(undef_bp));
    step_multi_c:  cover property (r_reg.step_active && insn_done && r_reg.step_cnt != STEP_ONE);
    dma_wait_c:    cover property (r_reg.st == sbb_pkg::ST_HOLD && dma_burst_busy);

endmodule

/* File: tb/sbb_mem_model.sv */
`timescale 1ns/1ps
module sbb_mem_model (
    // clock
    input  wire logic               ref_clk,
    // target memory port
    input  wire logic               mem_req,
    input  wire logic               mem_we,
    input  wire sbb_pkg::sbb_addr_t mem_addr,
    input  wire sbb_pkg::sbb_opc_t  mem_wdata,
    output logic                    mem_ack,
    output sbb_pkg::sbb_opc_t       mem_rdata
);
    sbb_pkg::sbb_opc_t mem [256];
    int                wait_c = 0;
    initial mem_ack = 1'b0;
    initial mem_rdata = 16'h0000;
    // writable ram only, so a plant never meets read-only space
    always @(posedge ref_clk)
    begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata; // stale read data is never left standing
        if (mem_req && !mem_ack && wait_c > 0)
            wait_c <= wait_c - 1;
        else if (mem_req && !mem_ack)
        begin
            mem_ack <= 1'b1;
            wait_c <= $urandom % 4; // mixes prompt and slow answers
            if (mem_we)
                mem[mem_addr[7:0]] <= mem_wdata;
            else
                mem_rdata <= mem[mem_addr[7:0]];
        end
    end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 0, rst_n = 0, cmd_valid = 0, cmd_use_addr = 1, fetch_valid = 0;
    logic insn_done = 0, dma_burst_busy = 0, mem_ack, cmd_ready, core_run, pc_load;
    logic mem_req, mem_we, in_monitor, bp_hit, undef_bp, step_done, sw_bp_enabled, tbl_full;
    logic [15:0] cmd_count = 0;
    sbb_pkg::sbb_cmd_t  cmd_op = sbb_pkg::CMD_RUN;
    sbb_pkg::sbb_addr_t cmd_addr = 0, fetch_addr = 0, pc_load_addr, mem_addr;
    sbb_pkg::sbb_opc_t  fetch_data = 0, mem_wdata, mem_rdata;
    int error_cnt = 0, checked = 0, pc_loads = 0, orig [8];
    localparam logic [23:0] MK = 24'h005770;
    sbb_break_ctrl #(.NUM_BP(2)) dut_u (.ref_clk, .rst_n, .cmd_valid, .cmd_op, .cmd_addr,
        .cmd_use_addr, .cmd_count, .cmd_ready, .fetch_valid, .fetch_addr, .fetch_data,
        .insn_done, .dma_burst_busy, .core_run, .pc_load, .pc_load_addr, .mem_req, .mem_we,
        .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .in_monitor, .bp_hit, .undef_bp,
        .step_done, .sw_bp_enabled, .tbl_full);
    sbb_mem_model mem_u (.ref_clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
        .mem_rdata);
    // free running 200 MHz clock
    initial forever #2.5 ref_clk = ~ref_clk;
    // pc_load is a one-cycle pulse, so count it rather than catch it
    always @(posedge ref_clk)
        if (pc_load) pc_loads <= pc_loads + 1;
    task automatic chk(string n, logic [23:0] seen, logic [23:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // offer one command, then wait until the controller is idle again
    task automatic cmd(sbb_pkg::sbb_cmd_t op, int a, int n);
        cmd_op <= op;
        cmd_addr <= a[23:0];
        cmd_count <= n[15:0];
        cmd_valid <= 1'b1;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
        for (int k = 0; k < 200 && !cmd_ready; k++) @(posedge ref_clk);
        chk("cmd_idle", cmd_ready, 1);
    endtask
    task automatic fetch_mon(int a);
        fetch_valid <= 1'b1;
        fetch_addr <= a[23:0];
        fetch_data <= MK[15:0];
        @(posedge ref_clk);
        fetch_valid <= 1'b0;
        for (int k = 0; k < 200 && !(in_monitor && cmd_ready); k++) @(posedge ref_clk);
        chk("fetch_idle", in_monitor && cmd_ready, 1);
    endtask
    // watchdog sized well above the whole sequence
    initial
    begin
        #100000;
        error_cnt++;
        stop_test();
    end
    // breakpoints only ever sit on opcode words in ram
    initial
    begin
        void'($urandom(72723));
        for (int i = 0; i < 8; i++)
        begin
            orig[i] = $urandom & 16'h0FFF; // never equals the marker
            mem_u.mem[16 * i] = orig[i][15:0];
        end
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        chk("enabled", sw_bp_enabled, 0);
        cmd(sbb_pkg::CMD_BP_EN, 0, 0);
        chk("enabled_on", sw_bp_enabled, 1);
        cmd(sbb_pkg::CMD_BP_SET, 16, 0);
        chk("plant", mem_u.mem[16], MK);
        cmd(sbb_pkg::CMD_RUN, 0, 0);
        chk("core_run", core_run, 1);
        fetch_mon(16);
        chk("bp_hit", bp_hit, 1);
        chk("monitor", in_monitor, 1);
        chk("restore", mem_u.mem[16], orig[1]);
        chk("resume", pc_load_addr, 16);
        $display("test hit done");
        cmd(sbb_pkg::CMD_RUN, 0, 0);
        fetch_mon(32);
        chk("undef", undef_bp, 1);
        chk("bp_hit2", bp_hit, 0);
        cmd(sbb_pkg::CMD_RUN, 0, 0);
        // break offered by hand: cmd_ready stays low for as long as the burst lasts
        dma_burst_busy <= 1'b1;
        cmd_op <= sbb_pkg::CMD_BREAK;
        cmd_valid <= 1'b1;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk("held", core_run, 1);
        chk("held_mon", in_monitor, 0);
        dma_burst_busy <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk("break", in_monitor, 1);
        chk("stopped", core_run, 0);
        $display("test break done");
        cmd(sbb_pkg::CMD_STEP, 16, 3);
        for (int i = 0; i < 3; i++)
        begin
            chk("step_early", step_done, 0);
            insn_done <= 1'b1;
            @(posedge ref_clk);
            insn_done <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
        repeat (4) @(posedge ref_clk);
        chk("step_done", step_done, 1);
        chk("step_pc", pc_load_addr, 16);
        chk("pc_loads", pc_loads[23:0], 5);
        $display("test step done");
        cmd(sbb_pkg::CMD_BP_SET, 48, 0);
        cmd(sbb_pkg::CMD_BP_SET, 64, 0);
        chk("full", tbl_full, 1);
        chk("no_plant", mem_u.mem[64], orig[4]);
        cmd(sbb_pkg::CMD_BP_DIS, 0, 0);
        chk("disable", mem_u.mem[48], orig[3]);
        chk("enabled_off", sw_bp_enabled, 0);
        cmd(sbb_pkg::CMD_BP_EN, 0, 0);
        chk("replant", mem_u.mem[48], MK);
        cmd(sbb_pkg::CMD_BP_CLR, 48, 0);
        chk("clear", mem_u.mem[48], orig[3]);
        chk("full_clr", tbl_full, 0);
        cmd(sbb_pkg::CMD_BP_CLR_ALL, 0, 0);
        chk("clear_all", mem_u.mem[16], orig[1]);
        $display("test table done");
        stop_test();
    end
endmodule
